// File: rtl/iepr_pkg.sv
// Constants for the interrupt enable and priority register block
// Functional notes
// R1: Enable bit one passes request, zero blocks
// R2: Unimplemented bits ignore writes, read zero
// R3: Priority code 111 is level seven
// R4: Code 001 is level one, linear between
// R5: Priority code 000 disables source entirely
// R6: Reset clears enables, priorities load 100
// R7: Enable bits 13-8 capture9 through uart4 receive
// R8: Enable bits 7,5-1 uart4 err, i2c3, uart3
// R9: Priority 0: timer1, compare1, capture1, ext0
// R10: Priority 1: timer2, compare2, capture2; 3-0 unused
// R11: Priority 2: uart1 rx, spi1 event/fault, timer3
// R12: Priority 3: adc done, uart1 tx; 15-7 unused
// R13: Highest enabled nonzero flagged priority wins
package iepr_pkg;

  // ----------------------------------------------------------------
  // Register word offsets (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_EN5 = 6'h00;
  localparam logic [5:0] IDX_PRIO0 = 6'h01;
  localparam logic [5:0] IDX_PRIO1 = 6'h02;
  localparam logic [5:0] IDX_PRIO2 = 6'h03;
  localparam logic [5:0] IDX_PRIO3 = 6'h04;
  localparam logic [5:0] IDX_STATUS = 6'h05;

  // ----------------------------------------------------------------
  // Implemented-bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_EN5 = 16'h3fbe;
  localparam logic [15:0] MASK_PRIO0 = 16'h7777;
  localparam logic [15:0] MASK_PRIO1 = 16'h7770;
  localparam logic [15:0] MASK_PRIO2 = 16'h7777;
  localparam logic [15:0] MASK_PRIO3 = 16'h0077;
  localparam logic [15:0] RST_EN5 = 16'h0000;
  localparam logic [15:0] RST_PRIO_ALL = 16'h4444;

  // ----------------------------------------------------------------
  // Priority field positions and sizes
  // ----------------------------------------------------------------
  localparam int FLD_HI = 12;
  localparam int FLD_MH = 8;
  localparam int FLD_ML = 4;
  localparam int FLD_LO = 0;
  localparam int NUM_EN_SRC = 12;
  localparam int NUM_PRIO_SRC = 13;
  localparam logic [2:0] LVL_OFF = 3'h0;

  // Enable bit position of each gated source, capture9 first
  localparam int EN_BIT [NUM_EN_SRC] = '{13, 12, 11, 10, 9, 8, 7, 5, 4, 3, 2, 1};

  // Status register layout: request, source, level
  localparam int ST_REQ = 8;
  localparam int ST_SRC = 4;
  localparam int ST_LVL = 0;

endpackage

// File: rtl/iepr_regs.sv
// Interrupt enable and priority registers with request arbitration
module iepr_regs #(
  parameter int ADR_W = 8
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Sources gated by the enable register
  input wire logic [iepr_pkg::NUM_EN_SRC-1:0] en_src_flag_i,
  output logic [iepr_pkg::NUM_EN_SRC-1:0] en_src_irq_o,
  // Sources ranked by the priority registers
  input wire logic [iepr_pkg::NUM_PRIO_SRC-1:0] prio_src_flag_i,
  input wire logic [iepr_pkg::NUM_PRIO_SRC-1:0] prio_src_en_i,
  // Request to the CPU arbitration
  output logic irq_req_o,
  output logic [3:0] irq_src_o,
  output logic [2:0] irq_level_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Merge a write into a register under byte lanes and implemented mask
  function automatic logic [15:0] merge(input logic [15:0] cur, input logic [31:0] wd,
                                        input logic [3:0] sel, input logic [15:0] mask);
    logic [15:0] v;
    v = cur;
    if (sel[0]) begin
      v[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      v[15:8] = wd[15:8];
    end
    merge = v & mask;
  endfunction

  // Pull one 3-bit priority field out of a register
  function automatic logic [2:0] field(input logic [15:0] r, input int lsb);
    field = r[lsb +: 3];
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] en5_ff;
  logic [15:0] prio0_ff;
  logic [15:0] prio1_ff;
  logic [15:0] prio2_ff;
  logic [15:0] prio3_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [5:0] idx;
  logic wr_now;
  logic [31:0] nxt_rdat;

  assign idx = adr_i[7:2];
  // Write lands on the edge where the master sees ack
  assign wr_now = ce_i && cyc_i && stb_i && we_i && ack_ff;

  // Bus acknowledge: one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= cyc_i && stb_i && !ack_ff;
    end
  end

  // Enable register; unimplemented positions never store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en5_ff <= iepr_pkg::RST_EN5; // see R6
    end else if (wr_now && idx == iepr_pkg::IDX_EN5) begin
      en5_ff <= merge(en5_ff, dat_i, sel_i, iepr_pkg::MASK_EN5); // see R2 see R7 see R8
    end
  end

  // Priority registers; every field resets to level four
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio0_ff <= iepr_pkg::RST_PRIO_ALL & iepr_pkg::MASK_PRIO0; // see R6
      prio1_ff <= iepr_pkg::RST_PRIO_ALL & iepr_pkg::MASK_PRIO1;
      prio2_ff <= iepr_pkg::RST_PRIO_ALL & iepr_pkg::MASK_PRIO2;
      prio3_ff <= iepr_pkg::RST_PRIO_ALL & iepr_pkg::MASK_PRIO3;
    end else if (wr_now) begin
      if (idx == iepr_pkg::IDX_PRIO0) begin
        prio0_ff <= merge(prio0_ff, dat_i, sel_i, iepr_pkg::MASK_PRIO0); // see R9
      end
      if (idx == iepr_pkg::IDX_PRIO1) begin
        prio1_ff <= merge(prio1_ff, dat_i, sel_i, iepr_pkg::MASK_PRIO1); // see R10
      end
      if (idx == iepr_pkg::IDX_PRIO2) begin
        prio2_ff <= merge(prio2_ff, dat_i, sel_i, iepr_pkg::MASK_PRIO2); // see R11
      end
      if (idx == iepr_pkg::IDX_PRIO3) begin
        prio3_ff <= merge(prio3_ff, dat_i, sel_i, iepr_pkg::MASK_PRIO3); // see R12
      end
    end
  end

  // ----------------------------------------------------------------
  // Level table of the ranked sources
  // ----------------------------------------------------------------
  logic [2:0] lvl [iepr_pkg::NUM_PRIO_SRC];

  // Field code is the level itself, so no decode table is needed
  always_comb begin
    lvl[0] = field(prio0_ff, iepr_pkg::FLD_HI); // see R3 see R4 see R9
    lvl[1] = field(prio0_ff, iepr_pkg::FLD_MH);
    lvl[2] = field(prio0_ff, iepr_pkg::FLD_ML);
    lvl[3] = field(prio0_ff, iepr_pkg::FLD_LO);
    lvl[4] = field(prio1_ff, iepr_pkg::FLD_HI); // see R10
    lvl[5] = field(prio1_ff, iepr_pkg::FLD_MH);
    lvl[6] = field(prio1_ff, iepr_pkg::FLD_ML);
    lvl[7] = field(prio2_ff, iepr_pkg::FLD_HI); // see R11
    lvl[8] = field(prio2_ff, iepr_pkg::FLD_MH);
    lvl[9] = field(prio2_ff, iepr_pkg::FLD_ML);
    lvl[10] = field(prio2_ff, iepr_pkg::FLD_LO);
    lvl[11] = field(prio3_ff, iepr_pkg::FLD_ML); // see R12
    lvl[12] = field(prio3_ff, iepr_pkg::FLD_LO);
  end

  // ----------------------------------------------------------------
  // Gating and arbitration
  // ----------------------------------------------------------------
  logic [iepr_pkg::NUM_EN_SRC-1:0] en_vec;
  logic nxt_req;
  logic [3:0] nxt_src;
  logic [2:0] nxt_lvl;

  // Gather the scattered enable bits into source order
  always_comb begin
    for (int i = 0; i < iepr_pkg::NUM_EN_SRC; i++) begin
      en_vec[i] = en5_ff[iepr_pkg::EN_BIT[i]];
    end
  end

  // Strictly-greater search: on a tie the lower source index wins
  always_comb begin
    nxt_req = 1'b0;
    nxt_src = 4'h0;
    nxt_lvl = iepr_pkg::LVL_OFF;
    for (int i = 0; i < iepr_pkg::NUM_PRIO_SRC; i++) begin
      if (prio_src_flag_i[i] && prio_src_en_i[i] && lvl[i] > nxt_lvl) begin // see R5 see R13
        nxt_req = 1'b1;
        nxt_src = 4'(i);
        nxt_lvl = lvl[i];
      end
    end
  end

  // Gated requests of the enable-register sources
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_src_irq_o <= '0;
    end else if (ce_i) begin
      en_src_irq_o <= en_src_flag_i & en_vec; // see R1
    end
  end

  // Winning request towards the CPU, one cycle of latency
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_o <= 1'b0;
      irq_src_o <= 4'h0;
      irq_level_o <= iepr_pkg::LVL_OFF;
    end else if (ce_i) begin
      irq_req_o <= nxt_req; // see R13
      irq_src_o <= nxt_src;
      irq_level_o <= nxt_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped addresses and the upper half-word read as zero
  always_comb begin
    nxt_rdat = 32'h0000_0000;
    case (idx)
      iepr_pkg::IDX_EN5: nxt_rdat[15:0] = en5_ff; // see R2
      iepr_pkg::IDX_PRIO0: nxt_rdat[15:0] = prio0_ff;
      iepr_pkg::IDX_PRIO1: nxt_rdat[15:0] = prio1_ff;
      iepr_pkg::IDX_PRIO2: nxt_rdat[15:0] = prio2_ff;
      iepr_pkg::IDX_PRIO3: nxt_rdat[15:0] = prio3_ff;
      iepr_pkg::IDX_STATUS: begin
        nxt_rdat[iepr_pkg::ST_REQ] = irq_req_o;
        nxt_rdat[iepr_pkg::ST_SRC +: 4] = irq_src_o;
        nxt_rdat[iepr_pkg::ST_LVL +: 3] = irq_level_o;
      end
      default: nxt_rdat = 32'h0000_0000;
    endcase
  end

  // Read data captured with the acknowledge, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      rdat_ff <= (cyc_i && stb_i && !ack_ff && !we_i) ? nxt_rdat : 32'h0000_0000;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = rdat_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [2:0] win_lvl_now;
  assign win_lvl_now = lvl[irq_src_o];

  // Gated output follows flag and enable of the previous cycle
  AST_GATE: assert property ( // see R1
      $past(ce_i) && !$past(rst_i) |-> en_src_irq_o == $past(en_src_flag_i & en_vec))
    else $error("gated request differs from flag and enable");

  // Unimplemented bits never hold a one
  AST_UNIMP: assert property ( // see R2
      (en5_ff & ~iepr_pkg::MASK_EN5) == 16'h0000
      && (prio0_ff & ~iepr_pkg::MASK_PRIO0) == 16'h0000
      && (prio1_ff & ~iepr_pkg::MASK_PRIO1) == 16'h0000
      && (prio2_ff & ~iepr_pkg::MASK_PRIO2) == 16'h0000
      && (prio3_ff & ~iepr_pkg::MASK_PRIO3) == 16'h0000)
    else $error("unimplemented bit holds a one");

  // Upper half of read data always zero
  AST_RD_UPPER: assert property (ack_o |-> dat_o[31:16] == 16'h0000) // see R2
    else $error("upper read data not zero");

  // Reset values after release, outputs quiet
  AST_RESET: assert property ( // see R6
      $past(rst_i) |-> en5_ff == iepr_pkg::RST_EN5
      && prio0_ff == (iepr_pkg::RST_PRIO_ALL & iepr_pkg::MASK_PRIO0)
      && prio1_ff == (iepr_pkg::RST_PRIO_ALL & iepr_pkg::MASK_PRIO1)
      && prio2_ff == (iepr_pkg::RST_PRIO_ALL & iepr_pkg::MASK_PRIO2)
      && prio3_ff == (iepr_pkg::RST_PRIO_ALL & iepr_pkg::MASK_PRIO3)
      && !ack_o && !irq_req_o && en_src_irq_o == '0)
    else $error("register reset value wrong");

  // A disabled level never reaches the CPU
  AST_NO_ZERO: assert property (irq_req_o |-> irq_level_o != iepr_pkg::LVL_OFF) // see R5
    else $error("request raised at level zero");

  // Reported level is the field of the reported source
  AST_LEVEL: assert property ( // see R3
      irq_req_o && $stable(prio0_ff) && $stable(prio1_ff) && $stable(prio2_ff)
      && $stable(prio3_ff) |-> irq_level_o == win_lvl_now)
    else $error("reported level does not match source field");

  // Enable write stores masked data on the ack edge
  AST_WR_EN: assert property ( // see R7 see R8
      wr_now && idx == iepr_pkg::IDX_EN5 && sel_i[1:0] == 2'h3
      |=> en5_ff == $past(dat_i[15:0] & iepr_pkg::MASK_EN5))
    else $error("enable write not stored");

  // A lane-0 write leaves the upper byte alone
  AST_LANE: assert property (
      wr_now && idx == iepr_pkg::IDX_EN5 && sel_i[1:0] == 2'h1
      |=> en5_ff[15:8] == $past(en5_ff[15:8]))
    else $error("unselected byte lane changed");

  // Priority register zero keeps its four fields
  AST_WR_P0: assert property ( // see R9
      wr_now && idx == iepr_pkg::IDX_PRIO0 && sel_i[1:0] == 2'h3
      |=> prio0_ff == $past(dat_i[15:0] & iepr_pkg::MASK_PRIO0))
    else $error("priority zero write wrong");

  // Priority register one drops its low nibble
  AST_WR_P1: assert property ( // see R10
      wr_now && idx == iepr_pkg::IDX_PRIO1 && sel_i[1:0] == 2'h3
      |=> prio1_ff == $past(dat_i[15:0] & iepr_pkg::MASK_PRIO1))
    else $error("priority one write wrong");

  // Priority register two keeps its four fields
  AST_WR_P2: assert property ( // see R11
      wr_now && idx == iepr_pkg::IDX_PRIO2 && sel_i[1:0] == 2'h3
      |=> prio2_ff == $past(dat_i[15:0] & iepr_pkg::MASK_PRIO2))
    else $error("priority two write wrong");

  // Priority register three keeps only its two fields
  AST_WR_P3: assert property ( // see R12
      wr_now && idx == iepr_pkg::IDX_PRIO3 && sel_i[1:0] == 2'h3
      |=> prio3_ff == $past(dat_i[15:0] & iepr_pkg::MASK_PRIO3))
    else $error("priority three write wrong");

  // A live request among the all-seven sources yields a CPU request
  AST_REQ: assert property ( // see R13
      ce_i && |(prio_src_flag_i[3:0] & prio_src_en_i[3:0]) && prio0_ff == iepr_pkg::MASK_PRIO0
      |=> irq_req_o)
    else $error("live request not presented");

  // Acknowledge lasts exactly one running cycle
  AST_ACK: assert property (ack_o && ce_i |=> !ack_o)
    else $error("acknowledge held too long");

  // Acknowledge only answers a request of the previous edge
  AST_ACK_REQ: assert property (ack_o && $past(ce_i) |-> $past(cyc_i && stb_i))
    else $error("acknowledge without request");

  // Read data stays zero outside an acknowledge
  AST_RD_IDLE: assert property (!ack_o |-> dat_o == 32'h0000_0000) // see R2
    else $error("read data outside acknowledge");

  // Enable read returns the stored value
  AST_RD_EN: assert property ( // see R2
      ack_o && !we_i && idx == iepr_pkg::IDX_EN5
      |-> dat_o[15:0] == $past(en5_ff))
    else $error("enable read data wrong");

  // Status read reflects the registered winner
  AST_RD_ST: assert property ( // see R13
      ack_o && !we_i && idx == iepr_pkg::IDX_STATUS
      |-> dat_o[iepr_pkg::ST_REQ] == $past(irq_req_o)
      && dat_o[iepr_pkg::ST_SRC +: 4] == $past(irq_src_o)
      && dat_o[iepr_pkg::ST_LVL +: 3] == $past(irq_level_o))
    else $error("status read data wrong");

  // No winner means source and level rest at zero
  AST_IDLE: assert property ( // see R13
      !irq_req_o |-> irq_src_o == 4'h0 && irq_level_o == iepr_pkg::LVL_OFF)
    else $error("idle request carries a source");

  // Clock enable low freezes enable, priority zero and three, and all outputs
  AST_CE_HOLD: assert property (!ce_i && !rst_i
      |=> $stable(ack_o) && $stable(dat_o) && $stable(en5_ff) && $stable(prio0_ff)
      && $stable(prio3_ff) && $stable(en_src_irq_o) && $stable(irq_req_o)
      && $stable(irq_src_o) && $stable(irq_level_o))
    else $error("state moved while clock enable low");

  // Main scenarios worth seeing once
  COV_WRITE: cover property (wr_now && idx == iepr_pkg::IDX_EN5);
  COV_TOP: cover property (irq_req_o && irq_level_o == 3'h7);
  COV_GATED: cover property (|en_src_irq_o);
  COV_READ_ST: cover property (ack_o && !we_i && idx == iepr_pkg::IDX_STATUS);
  COV_HOLD: cover property (!ce_i && |en_src_irq_o);

endmodule

// File: tb/iepr_src_model.sv
// Peripheral flag sources facing the register block
module iepr_src_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Levels commanded by the bench
  input wire logic [37:0] cmd_i,
  // Flags and their outside enables
  output logic [11:0] en_flag_o,
  output logic [12:0] prio_flag_o,
  output logic [12:0] prio_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Flags leave flops, as real status bits do, so they never glitch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {prio_en_o, prio_flag_o, en_flag_o} <= 38'h0;
    end else begin
      {prio_en_o, prio_flag_o, en_flag_o} <= cmd_i;
    end
  end
endmodule

// File: tb/irq_enable_priority_regs_tb_top.sv
// Self-checking bench for the enable and priority register block
module irq_enable_priority_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MSK [5] = '{16'h3fbe, 16'h7777, 16'h7770, 16'h7777, 16'h0077};
  localparam logic [15:0] RST [5] = '{16'h0000, 16'h4444, 16'h4440, 16'h4444, 16'h0044};
  localparam int PR_REG [13] = '{1, 1, 1, 1, 2, 2, 2, 3, 3, 3, 3, 4, 4};
  localparam int PR_SH [13] = '{12, 8, 4, 0, 12, 8, 4, 12, 8, 4, 0, 4, 0};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [37:0] cmd = 38'h0;
  logic [11:0] en_flag;
  logic [11:0] en_irq;
  logic [12:0] pr_flag;
  logic [12:0] pr_en;
  logic irq_req;
  logic [3:0] irq_src;
  logic [2:0] irq_lvl;
  logic [31:0] seed = 32'h1b97;
  logic [15:0] rv [5];
  logic [15:0] q;
  logic [7:0] w;
  int fails = 0;
  int n_checks = 0;

  // Free-running 50 MHz clock
  always #10 clk_i = ~clk_i;

  iepr_src_model iepr_src_model_inst (.clk_i, .rst_i, .cmd_i(cmd), .en_flag_o(en_flag),
    .prio_flag_o(pr_flag), .prio_en_o(pr_en));
  iepr_regs iepr_regs_inst (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .en_src_flag_i(en_flag), .en_src_irq_o(en_irq),
    .prio_src_flag_i(pr_flag), .prio_src_en_i(pr_en), .irq_req_o(irq_req),
    .irq_src_o(irq_src), .irq_level_o(irq_lvl));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Winner: highest nonzero level, strict compare keeps lowest index on ties
  function automatic logic [7:0] win(input logic [12:0] f, input logic [12:0] e);
    logic [7:0] r;
    logic [2:0] l;
    r = 8'h00;
    for (int s = 0; s < 13; s++) begin
      l = rv[PR_REG[s]][PR_SH[s] +: 3];
      if (f[s] && e[s] && l > r[2:0]) r = {1'b1, s[3:0], l};
    end
    return r;
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Classic single cycle; ack and data sampled at the rising edge, the watchdog ends a hang
  task automatic wb(input int r, input logic w, input logic [15:0] d, input logic [3:0] s);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i} <= {2'b11, w};
    adr_i <= 8'(r * 4);
    sel_i <= s;
    dat_i <= {16'hffff, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o[15:0];
    {cyc_i, stb_i} <= 2'b00;
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int r = 0; r < 5; r++) begin
      wb(r, 1'b0, 16'h0, 4'h3);
      chk("reset value", q, RST[r]);
      rv[r] = RST[r];
    end
    wb(63, 1'b0, 16'h0, 4'h3);
    chk("unmapped read", q, 16'h0000);
    $display("test reset done");
    for (int r = 0; r < 5; r++) begin
      seed = lfsr(seed);
      wb(r, 1'b1, seed[15:0], 4'h3);
      wb(r, 1'b1, 16'hffff, 4'h1);
      wb(r, 1'b0, 16'h0, 4'h3);
      chk("readback", q, {seed[15:8], 8'hff} & MSK[r]);
    end
    $display("test access done");
    // Gating: all-ones corner first, then random enables and flags
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      rv[0] = (i == 0) ? MSK[0] : seed[15:0] & MSK[0];
      wb(0, 1'b1, (i == 0) ? 16'hffff : seed[15:0], 4'h3);
      seed = lfsr(seed);
      cmd <= {26'h0, (i == 0) ? 12'hfff : seed[11:0]};
      repeat (3) @(posedge clk_i);
      for (int b = 0; b < 12; b++) begin
        chk("gated request", {15'h0, en_irq[b]},
          {15'h0, en_flag[b] & rv[0][iepr_pkg::EN_BIT[b]]});
      end
    end
    // Clock enable low: gated requests hold while the flags flip
    for (int b = 0; b < 12; b++) begin
      q[b] = en_flag[b] & rv[0][iepr_pkg::EN_BIT[b]];
    end
    q[15:12] = 4'h0;
    ce_i <= 1'b0;
    cmd <= {26'h0, ~en_flag};
    repeat (3) @(posedge clk_i);
    chk("held request", {4'h0, en_irq}, q);
    ce_i <= 1'b1;
    $display("test gating done");
    // Ranking: all 7, all 0, all 1, then random levels
    for (int i = 0; i < 24; i++) begin
      for (int r = 1; r < 5; r++) begin
        seed = lfsr(seed);
        q = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : (i == 2) ? 16'h1111 : seed[15:0];
        rv[r] = q & MSK[r];
        wb(r, 1'b1, q, 4'h3);
      end
      seed = lfsr(seed);
      cmd <= (i < 3) ? {26'h3ffffff, 12'h0} : {seed[25:0], 12'h0};
      repeat (3) @(posedge clk_i);
      w = win(pr_flag, pr_en);
      chk("request", {15'h0, irq_req}, {15'h0, w[7]});
      if (w[7]) begin
        chk("source", {12'h0, irq_src}, {12'h0, w[6:3]});
        chk("level", {13'h0, irq_lvl}, {13'h0, w[2:0]});
      end
      wb(5, 1'b0, 16'h0, 4'h3);
      chk("status", q, {7'h0, w[7], w[6:3], 1'b0, w[2:0]});
    end
    $display("test ranking done");
    finish_test;
  end

  // Watchdog well past the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    finish_test;
  end
endmodule
